// file: design/bsc_pkg.sv
// package: constants and types of the barometric sensor command engine
`default_nettype none
package bsc_pkg;
  localparam int SYS_CLK_MHZ = 200;
  localparam int INIT_TIME_US = 400;
  localparam int INIT_CYC = INIT_TIME_US * SYS_CLK_MHZ;
  // one channel's conversion time in microseconds, per ratio setting
  localparam int CONV_US_4096 = 65600;
  localparam int CONV_US_2048 = 32800;
  localparam int CONV_US_1024 = 16400;
  localparam int CONV_US_512 = 8200;
  localparam int CONV_US_256 = 4100;
  localparam int CONV_US_128 = 2100;
  localparam int CONV_W = 24;
  // slice n holds the cycle count of ratio code n
  localparam logic [6*CONV_W-1:0] CONV_CYC_ALL = {
    CONV_W'(CONV_US_128 * SYS_CLK_MHZ),
    CONV_W'(CONV_US_256 * SYS_CLK_MHZ),
    CONV_W'(CONV_US_512 * SYS_CLK_MHZ),
    CONV_W'(CONV_US_1024 * SYS_CLK_MHZ),
    CONV_W'(CONV_US_2048 * SYS_CLK_MHZ),
    CONV_W'(CONV_US_4096 * SYS_CLK_MHZ)};
  localparam logic [2:0] RATIO_CODE_MAX = 3'h5;
  // command bytes
  localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
  localparam logic [7:0] CMD_READ_TEMP_PRESS = 8'h10;
  localparam logic [7:0] CMD_READ_TEMP_ALT = 8'h11;
  localparam logic [7:0] CMD_READ_PRESS = 8'h30;
  localparam logic [7:0] CMD_READ_ALT = 8'h31;
  localparam logic [7:0] CMD_READ_TEMP = 8'h32;
  localparam logic [7:0] CMD_ANALOG_RECAL = 8'h28;
  localparam logic [2:0] CONV_PREFIX = 3'h2;
  localparam logic [1:0] REG_RD_PREFIX = 2'h2;
  localparam logic [1:0] REG_WR_PREFIX = 2'h3;
  localparam logic [1:0] CHAN_TEMP_PRESS = 2'h0;
  localparam logic [1:0] CHAN_TEMP = 2'h2;
  // link target address
  localparam logic [6:0] TARGET_ADDR = 7'h76;
  // control registers
  localparam logic [5:0] INT_SOURCE_ADDR = 6'h0d;
  localparam logic [5:0] COMP_CTRL_ADDR = 6'h0e;
  localparam int READY_BIT = 0;
  localparam int CONV_FAIL_BIT = 1;
  localparam int COMP_EN_BIT = 0;
  localparam logic [7:0] COMP_CTRL_RESET = 8'h00;
  localparam int TRIM_BYTES = 128;
  localparam logic [6:0] TRIM_LAST = 7'h7f;
  localparam logic [47:0] TX_IDLE = 48'hffff_ffff_ffff;
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } bsc_rx_byte_t;
  typedef struct packed {
    logic [2:0] prefix;
    logic [2:0] ratio;
    logic [1:0] chan;
  } bsc_conv_cmd_t;
endpackage
`default_nettype wire

// file: design/bsc_engine.sv
// barometric sensor command engine: link target, decoder and sequencer
`timescale 1ns/100ps
`default_nettype none
module bsc_engine #(
  parameter int unsigned INIT_CYCLES = bsc_pkg::INIT_CYC,
  parameter logic [6*bsc_pkg::CONV_W-1:0] CONV_CYCLES =
    bsc_pkg::CONV_CYC_ALL
) (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // two-wire link, clock from the host
  input wire logic i_scl,
  input wire logic i_sda,
  output var logic o_sda_out,
  output var logic o_sda_oe,
  // analog front end and altitude calculator
  input wire logic [19:0] i_adc_temp,
  input wire logic [19:0] i_adc_press,
  input wire logic [23:0] i_altitude,
  // factory trim programming
  input wire logic i_trim_we,
  input wire logic [6:0] i_trim_addr,
  input wire logic [7:0] i_trim_wdata,
  // status
  output var logic o_dev_ready,
  output var logic o_asleep,
  output var logic o_conv_fail,
  output var logic o_comp_en
);
  typedef enum logic [1:0] {
    L_ADDR, L_WRITE, L_READ, L_IGNORE
  } bsc_link_state_t;
  typedef enum logic [2:0] {
    S_INIT, S_CALIB, S_SLEEP, S_CONV_T, S_CONV_P, S_RECAL
  } bsc_sys_state_t;

  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic start_ev, stop_ev, frame_rst, bus_stopped, link_rst_n;
  bsc_link_state_t lstate;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sr;
  logic rx_first, rx_tog;
  bsc_pkg::bsc_rx_byte_t rx_word;
  logic [47:0] tx_sr, tx_buf;
  logic tog_s1, tog_s2, tog_d;
  logic byte_ev, cmd_ev, data_ev, srst_ev;
  logic [7:0] cmd;
  bsc_pkg::bsc_conv_cmd_t conv;
  logic is_conv, conv_bad, conv_go, conv_rej, recal_go;
  logic [23:0] cmd_cyc, conv_cyc_q, timer;
  logic both_q, comp_q;
  bsc_sys_state_t state, next_state;
  logic [6:0] trim_idx;
  logic [7:0] trim_mem [bsc_pkg::TRIM_BYTES];
  logic [15:0] temp_off, press_off;
  logic [23:0] res_temp, res_press, res_alt;
  logic [19:0] temp_val, press_val;
  logic [7:0] comp_ctrl, reg_val;
  logic wr_pend;
  logic [5:0] wr_addr;

  // ---------------- start and stop detection on the system clock
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;

  // start or stop resets the link logic; a start releases it while scl is
  // low, which is far longer than the synchroniser delay
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_rst <= 1'b1;
      bus_stopped <= 1'b1;
    end else if (start_ev) begin
      frame_rst <= 1'b1;
      bus_stopped <= 1'b0;
    end else if (stop_ev) begin
      frame_rst <= 1'b1;
      bus_stopped <= 1'b1;
    end else if (!scl_s2 && !bus_stopped) begin
      frame_rst <= 1'b0;
    end
  end

  assign link_rst_n = i_resetn & ~frame_rst;

  // ---------------- link domain: bits sampled on rising scl
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lstate <= L_ADDR;
      bit_cnt <= 4'h0;
      rx_sr <= 8'h00;
      rx_first <= 1'b1;
    end else begin
      if (bit_cnt == 4'h8) begin
        bit_cnt <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        rx_sr <= {rx_sr[6:0], i_sda};
      end
      case (lstate)
        L_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (rx_sr[7:1] != bsc_pkg::TARGET_ADDR) begin
              lstate <= L_IGNORE;
            end else if (rx_sr[0]) begin
              lstate <= L_READ;
            end else begin
              lstate <= L_WRITE;
            end
          end
        end
        L_WRITE: begin
          if (bit_cnt == 4'h8) begin
            rx_first <= 1'b0;
          end
        end
        L_READ: begin
          // host not-acknowledge ends the read
          if (bit_cnt == 4'h8 && i_sda) begin
            lstate <= L_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // the toggle survives frame resets so no byte event is lost or faked
  always_ff @(posedge i_scl or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_word <= '0;
      rx_tog <= 1'b0;
    end else if (lstate == L_WRITE && bit_cnt == 4'h7) begin
      rx_word.first <= rx_first;
      rx_word.data <= {rx_sr[6:0], i_sda};
      rx_tog <= ~rx_tog;
    end
  end

  // tx_buf only changes on a command byte, a frame before it is read out
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_sr <= bsc_pkg::TX_IDLE;
    end else if (lstate == L_ADDR && bit_cnt == 4'h8) begin
      tx_sr <= tx_buf;
    end else if (lstate == L_READ && bit_cnt != 4'h8) begin
      tx_sr <= {tx_sr[46:0], 1'b1};
    end
  end

  // open-drain drive changes on falling scl only
  always_ff @(negedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      case (lstate)
        L_ADDR: o_sda_oe <= (bit_cnt == 4'h8) &&
          (rx_sr[7:1] == bsc_pkg::TARGET_ADDR);
        L_WRITE: o_sda_oe <= (bit_cnt == 4'h8);
        L_READ: o_sda_oe <= (bit_cnt != 4'h8) && !tx_sr[47];
        default: o_sda_oe <= 1'b0;
      endcase
    end
  end

  // ---------------- byte events into the system domain
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_d <= 1'b0;
    end else begin
      tog_s1 <= rx_tog;
      tog_s2 <= tog_s1;
      tog_d <= tog_s2;
    end
  end

  assign byte_ev = tog_s2 ^ tog_d;
  assign cmd_ev = byte_ev & rx_word.first;
  assign data_ev = byte_ev & ~rx_word.first;
  assign cmd = rx_word.data;
  assign conv = bsc_pkg::bsc_conv_cmd_t'(cmd);
  assign srst_ev = cmd_ev && (cmd == bsc_pkg::CMD_SOFT_RESET);
  assign is_conv = (conv.prefix == bsc_pkg::CONV_PREFIX);
  assign conv_bad = conv.chan[0] ||
    (conv.ratio > bsc_pkg::RATIO_CODE_MAX);
  assign conv_go = cmd_ev && is_conv && !conv_bad && (state == S_SLEEP);
  assign conv_rej = cmd_ev && is_conv && conv_bad;
  assign recal_go = cmd_ev && (cmd == bsc_pkg::CMD_ANALOG_RECAL) &&
    (state == S_SLEEP);
  // ratio code picks the decimation and so the duration
  assign cmd_cyc = conv_bad ? 24'h000001 :
    CONV_CYCLES[int'(conv.ratio) * bsc_pkg::CONV_W +: bsc_pkg::CONV_W];

  // ---------------- sequencer
  always_comb begin
    next_state = state;
    if (srst_ev) begin
      next_state = S_INIT;
    end else begin
      case (state)
        S_INIT: if (timer == 24'h0) next_state = S_CALIB;
        S_CALIB: begin
          if (trim_idx == bsc_pkg::TRIM_LAST) begin
            next_state = S_SLEEP;
          end
        end
        S_SLEEP: begin
          if (conv_go) begin
            next_state = S_CONV_T;
          end else if (recal_go) begin
            next_state = S_RECAL;
          end
        end
        S_CONV_T: begin
          if (timer == 24'h0) begin
            next_state = both_q ? S_CONV_P : S_SLEEP;
          end
        end
        S_CONV_P: if (timer == 24'h0) next_state = S_SLEEP;
        S_RECAL: begin
          if (trim_idx == bsc_pkg::TRIM_LAST) begin
            next_state = S_SLEEP;
          end
        end
        default: next_state = S_INIT;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_INIT;
      o_asleep <= 1'b0;
    end else begin
      state <= next_state;
      o_asleep <= (next_state == S_SLEEP);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timer <= 24'(INIT_CYCLES - 1);
    end else if (next_state != state || srst_ev) begin
      case (next_state)
        S_INIT: timer <= 24'(INIT_CYCLES - 1);
        S_CONV_T: timer <= cmd_cyc - 24'h1;
        S_CONV_P: timer <= conv_cyc_q - 24'h1;
        default: timer <= 24'h0;
      endcase
    end else if (timer != 24'h0) begin
      timer <= timer - 24'h1;
    end
  end

  // settings latched when a conversion starts
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_cyc_q <= 24'h0;
      both_q <= 1'b0;
      comp_q <= 1'b0;
    end else if (conv_go) begin
      conv_cyc_q <= cmd_cyc;
      both_q <= (conv.chan == bsc_pkg::CHAN_TEMP_PRESS);
      comp_q <= comp_ctrl[bsc_pkg::COMP_EN_BIT];
    end
  end

  // ---------------- trim memory and calibration walk
  // no reset: the contents model nonvolatile storage
  always_ff @(posedge i_sys_clk) begin
    if (i_trim_we) begin
      trim_mem[i_trim_addr] <= i_trim_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trim_idx <= 7'h0;
    end else if (state == S_CALIB || state == S_RECAL) begin
      trim_idx <= trim_idx + 7'h1;
    end else begin
      trim_idx <= 7'h0;
    end
  end

  // bytes 0..3 of the trim walk hold the two offsets
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      temp_off <= 16'h0;
      press_off <= 16'h0;
    end else if (srst_ev) begin
      temp_off <= 16'h0;
      press_off <= 16'h0;
    end else if (state == S_CALIB || state == S_RECAL) begin
      case (trim_idx)
        7'h0: temp_off[15:8] <= trim_mem[trim_idx];
        7'h1: temp_off[7:0] <= trim_mem[trim_idx];
        7'h2: press_off[15:8] <= trim_mem[trim_idx];
        7'h3: press_off[7:0] <= trim_mem[trim_idx];
        default: begin
        end
      endcase
    end
  end

  // ---------------- results, kept through sleep
  assign temp_val = comp_q ?
    i_adc_temp + {{4{temp_off[15]}}, temp_off} : i_adc_temp;
  assign press_val = comp_q ?
    i_adc_press + {{4{press_off[15]}}, press_off} : i_adc_press;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      res_temp <= 24'h0;
      res_press <= 24'h0;
      res_alt <= 24'h0;
    end else if (srst_ev) begin
      res_temp <= 24'h0;
      res_press <= 24'h0;
      res_alt <= 24'h0;
    end else if (state == S_CONV_T && timer == 24'h0) begin
      // sign-extend into the four spare bits
      res_temp <= {{4{temp_val[19]}}, temp_val};
    end else if (state == S_CONV_P && timer == 24'h0) begin
      res_press <= {4'h0, press_val};
      // altitude arrives already in signed centimetres
      res_alt <= i_altitude;
    end
  end

  // ---------------- control registers
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 6'h0;
    end else if (cmd_ev) begin
      wr_pend <= (cmd[7:6] == bsc_pkg::REG_WR_PREFIX);
      wr_addr <= cmd[5:0];
    end else if (data_ev) begin
      wr_pend <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      comp_ctrl <= bsc_pkg::COMP_CTRL_RESET;
      o_comp_en <= 1'b0;
    end else begin
      if (srst_ev) begin
        comp_ctrl <= bsc_pkg::COMP_CTRL_RESET;
      end else if (data_ev && wr_pend &&
                   wr_addr == bsc_pkg::COMP_CTRL_ADDR) begin
        comp_ctrl <= cmd;
      end
      o_comp_en <= comp_ctrl[bsc_pkg::COMP_EN_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dev_ready <= 1'b0;
    end else if (srst_ev) begin
      o_dev_ready <= 1'b0;
    end else if (state == S_CALIB && trim_idx == bsc_pkg::TRIM_LAST) begin
      o_dev_ready <= 1'b1;
    end
  end

  // a rejected conversion is flagged and leaves the results alone
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv_fail <= 1'b0;
    end else if (conv_rej) begin
      o_conv_fail <= 1'b1;
    end else if (srst_ev || conv_go) begin
      o_conv_fail <= 1'b0;
    end
  end

  always_comb begin
    reg_val = 8'h00;
    if (cmd[5:0] == bsc_pkg::INT_SOURCE_ADDR) begin
      reg_val[bsc_pkg::READY_BIT] = o_dev_ready;
      reg_val[bsc_pkg::CONV_FAIL_BIT] = o_conv_fail;
    end else if (cmd[5:0] == bsc_pkg::COMP_CTRL_ADDR) begin
      reg_val = comp_ctrl;
    end
  end

  // ---------------- answer buffer for the next read frame
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_buf <= bsc_pkg::TX_IDLE;
    end else if (srst_ev) begin
      tx_buf <= bsc_pkg::TX_IDLE;
    end else if (cmd_ev) begin
      if (cmd == bsc_pkg::CMD_READ_TEMP_PRESS) begin
        tx_buf <= {res_temp, res_press};
      end else if (cmd == bsc_pkg::CMD_READ_TEMP_ALT) begin
        tx_buf <= {res_temp, res_alt};
      end else if (cmd == bsc_pkg::CMD_READ_PRESS) begin
        tx_buf <= {res_press, 24'hffffff};
      end else if (cmd == bsc_pkg::CMD_READ_ALT) begin
        tx_buf <= {res_alt, 24'hffffff};
      end else if (cmd == bsc_pkg::CMD_READ_TEMP) begin
        tx_buf <= {res_temp, 24'hffffff};
      end else if (cmd[7:6] == bsc_pkg::REG_RD_PREFIX) begin
        tx_buf <= {reg_val, 40'hff_ffff_ffff};
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/bsc_engine_assertions.sv
// checker: timing relations seen at the command engine's ports
`timescale 1ns/100ps
`default_nettype none
module bsc_engine_chk #(
  parameter int unsigned INIT_CYCLES = 100,
  parameter logic [6*bsc_pkg::CONV_W-1:0] CONV_CYCLES = '0
) (
  // clock, reset and link
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // status
  input wire logic o_dev_ready,
  input wire logic o_asleep,
  input wire logic o_conv_fail
);
  int unsigned wake_cnt;
  int unsigned low_cnt;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) wake_cnt <= 0;
    else wake_cnt <= o_dev_ready ? 0 : wake_cnt + 1;
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) low_cnt <= 0;
    else low_cnt <= o_asleep ? 0 : low_cnt + 1;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  chk_ready_sleep: assert property (
    $rose(o_dev_ready) |-> o_asleep) else $error("ready rose outside sleep");
  chk_init_len: assert property ($rose(o_dev_ready) |->
    wake_cnt >= INIT_CYCLES + 120) else $error("power-up too short");
  chk_sleep_ready: assert property (o_asleep |-> o_dev_ready)
    else $error("asleep before power-up ended");
  chk_ready_hold: assert property ($fell(o_dev_ready) |=>
    (!o_dev_ready)[*8]) else $error("power-up not rerun");
  chk_conv_len: assert property (
    $rose(o_asleep) && $past(o_dev_ready) |->
    low_cnt >= CONV_CYCLES[5*bsc_pkg::CONV_W +: bsc_pkg::CONV_W])
    else $error("job shorter than fastest conversion");
  chk_fail_asleep: assert property (
    $rose(o_conv_fail) |-> o_asleep)
    else $error("invalid conversion left sleep");
  chk_oe_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data driven while link clock high");
  chk_sda_out_low: assert property (o_sda_out == 1'b0)
    else $error("open-drain value not low");
  cover property ($rose(o_conv_fail));
  cover property ($fell(o_dev_ready));
  cover property ($rose(o_sda_oe));
endmodule
bind bsc_engine bsc_engine_chk #(.INIT_CYCLES(INIT_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)) bsc_engine_chk_inst (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_scl(i_scl), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_dev_ready(o_dev_ready), .o_asleep(o_asleep),
  .o_conv_fail(o_conv_fail));
`default_nettype wire

// file: sim/bsc_host.sv
// partner model: link controller that frames commands and reads
`timescale 1ns/100ps
`default_nettype none
module bsc_host (
  // link pins
  output var logic o_scl,
  output var logic o_sda,
  input wire logic i_sda
);
  // quarter of the 80 ns link period; the clock stands high between frames
  localparam realtime Q = 20.0;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic start_cond();
    #7.1;
    o_sda = 1'b0;
    #(2*Q);
    o_scl = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #Q;
    o_sda = b;
    #Q;
    o_scl = 1'b1;
    #Q;
    r = i_sda;
    #Q;
    o_scl = 1'b0;
  endtask
  // a released line (1) reads back the far side through the pull-up
  task automatic xfer(input logic [7:0] tx, input logic last,
    output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(last, ack);
  endtask
  task automatic stop_cond();
    #Q;
    o_sda = 1'b0;
    #Q;
    o_scl = 1'b1;
    #Q;
    o_sda = 1'b1;
    // bus free time before the next frame
    #1600;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// testbench: host model drives the engine; a result model checks each read
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // shortened counts; slice n is ratio code n
  localparam logic [143:0] CONV = {24'd40, 24'd60, 24'd80, 24'd100,
    24'd120, 24'd400};
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl;
  logic sda_h;
  logic sda_out;
  logic sda_oe;
  logic ready;
  logic asleep;
  logic conv_fail;
  logic comp_en;
  logic [19:0] adc_t = 20'h0;
  logic [19:0] adc_p = 20'h0;
  logic [23:0] alt = 24'h0;
  logic trim_we = 1'b0;
  logic [6:0] trim_addr = 7'h0;
  logic [7:0] trim_data = 8'h0;
  logic [31:0] seed = 32'h3c6e4338;
  logic [23:0] mt = 24'h0;
  logic [23:0] mp = 24'h0;
  logic [23:0] ma = 24'h0;
  logic [7:0] q[$];
  int fails = 0;
  int n_compared = 0;
  int run_len = 0;
  int last_len = 0;
  int n_runs = 0;
  wire sda_w = sda_h & (sda_oe ? sda_out : 1'b1);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (asleep !== 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      n_runs <= n_runs + 1;
      run_len <= 0;
    end
  end
  bsc_engine #(.INIT_CYCLES(100), .CONV_CYCLES(CONV)) bsc_engine_inst (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_adc_temp(adc_t),
    .i_adc_press(adc_p), .i_altitude(alt), .i_trim_we(trim_we),
    .i_trim_addr(trim_addr), .i_trim_wdata(trim_data),
    .o_dev_ready(ready), .o_asleep(asleep), .o_conv_fail(conv_fail),
    .o_comp_en(comp_en));
  bsc_host bsc_host_inst (.o_scl(scl), .o_sda(sda_h), .i_sda(sda_w));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] c, input logic [7:0] d, input bit two);
    logic [7:0] r;
    logic a;
    bsc_host_inst.start_cond();
    bsc_host_inst.xfer(8'hec, 1'b1, r, a);
    cmp({7'h0, a}, 8'h00);
    bsc_host_inst.xfer(c, 1'b1, r, a);
    cmp({7'h0, a}, 8'h00);
    if (two) begin
      bsc_host_inst.xfer(d, 1'b1, r, a);
      cmp({7'h0, a}, 8'h00);
    end
    bsc_host_inst.stop_cond();
  endtask
  // command frame, then a read frame checked byte by byte against q
  task automatic rd(input logic [7:0] c);
    logic [7:0] r;
    logic a;
    int n;
    send(c, 8'h00, 1'b0);
    n = q.size();
    bsc_host_inst.start_cond();
    bsc_host_inst.xfer(8'hed, 1'b1, r, a);
    cmp({7'h0, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      bsc_host_inst.xfer(8'hff, i == n - 1, r, a);
      cmp(r, q.pop_front());
    end
    bsc_host_inst.stop_cond();
  endtask
  task automatic push3(input logic [23:0] v);
    q.push_back(v[23:16]);
    q.push_back(v[15:8]);
    q.push_back(v[7:0]);
  endtask
  task automatic rd_res(input logic [7:0] c);
    if (c == 8'h10 || c == 8'h11 || c == 8'h32) push3(mt);
    if (c == 8'h10 || c == 8'h30) push3(mp);
    if (c == 8'h11 || c == 8'h31) push3(ma);
    rd(c);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 2000 && ready !== 1'b1; i++)
      @(negedge sys_clk);
    if (ready !== 1'b1) begin
      $display("BAD %0t: ready never came", $time);
      fails++;
      wrap_up();
    end
  endtask
  task automatic convert(input logic [2:0] code, input logic [1:0] ch);
    logic [31:0] x;
    int e;
    int runs;
    bit ok;
    x = rnd();
    @(negedge sys_clk);
    adc_t = x[19:0];
    x = rnd();
    adc_p = x[19:0];
    alt = 24'(rnd() >> 8);
    ok = code <= 3'h5 && !ch[0];
    runs = n_runs;
    send({3'b010, code, ch}, 8'h00, 1'b0);
    // slow jobs outlast the command frame; a lost job shows in the run count
    for (int i = 0; i < 4000 && ok && n_runs == runs; i++)
      @(negedge sys_clk);
    if (ok) begin
      e = int'(CONV[code*24 +: 24]) * (ch == 2'h0 ? 2 : 1);
      mt = {{4{adc_t[19]}}, adc_t};
      if (ch == 2'h0) begin
        mp = {4'h0, adc_p};
        ma = alt;
      end
      cmp(8'(last_len >= e && last_len <= e + 4), 8'h01);
      cmp(8'(n_runs - runs), 8'h01);
    end
    cmp({6'h0, conv_fail, asleep}, {6'h0, !ok, 1'b1});
    rd_res(8'h10);
  endtask
  initial begin
    logic [7:0] r;
    logic a;
    int runs;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    wait_ready();
    cmp({6'h0, ready, asleep}, 8'h03);
    q = {8'h01};
    rd(8'h8d);
    q = {8'h00};
    rd(8'hbf);
    $display("power-up test done");
    // zero offsets keep compensated results equal to the raw ones
    for (int i = 0; i < 128; i++) begin
      @(negedge sys_clk);
      trim_we = 1'b1;
      trim_addr = 7'(i);
      trim_data = i < 4 ? 8'h00 : 8'(rnd());
    end
    @(negedge sys_clk);
    trim_we = 1'b0;
    runs = n_runs;
    send(8'h28, 8'h00, 1'b0);
    cmp(8'(n_runs - runs), 8'h01);
    cmp(8'(last_len >= 128), 8'h01);
    cmp({6'h0, ready, asleep}, 8'h03);
    send(8'hce, 8'h01, 1'b1);
    cmp({7'h0, comp_en}, 8'h01);
    q = {8'h01};
    rd(8'h8e);
    bsc_host_inst.start_cond();
    bsc_host_inst.xfer(8'hee, 1'b1, r, a);
    bsc_host_inst.stop_cond();
    cmp({7'h0, a}, 8'h01);
    $display("register test done");
    for (int i = 0; i < 8; i++)
      convert(3'(i), {i[0], 1'b0});
    convert(3'h5, 2'h1);
    convert(3'h4, 2'h3);
    q = {8'h03};
    rd(8'h8d);
    rd_res(8'h30);
    rd_res(8'h31);
    rd_res(8'h32);
    rd_res(8'h11);
    $display("conversion test done");
    send(8'h40, 8'h00, 1'b0);
    send(8'h06, 8'h00, 1'b0);
    wait_ready();
    {mt, mp, ma} = '0;
    cmp({6'h0, comp_en, asleep}, 8'h01);
    rd_res(8'h10);
    $display("soft reset test done");
    wrap_up();
  end
  initial begin
    #450us;
    $display("BAD %0t: run too long", $time);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
